// File: hdl/switch_adv_control_slice.sv
// Purpose: advanced control slice: queue scheduling select, link-change
//          interrupt, forced-pause limit, source vlan tag insertion
// Assumes: link levels arrive from other domains; pause and queue
//          settings come from logic on clk
// Notes:   read data appears one cycle after reg_rd
`timescale 1ns/1ps
`default_nettype none
`include "switch_adv_consts.svh"

module switch_adv_control_slice
  import switch_adv_pkg::*;
#(
  parameter int unsigned PAUSE_LIMIT_CYCLES =
    `PAUSE_LIMIT_MS * (`CLK_HZ / 1000)
) (
  input  wire logic        clk,            // 25 MHz
  input  wire logic        rst,            // async, active high
  input  wire logic [7:0]  reg_addr,       // register offset
  input  wire logic        reg_wr,         // write strobe
  input  wire logic        reg_rd,         // read strobe
  input  wire logic [7:0]  reg_wdata,      // write data
  output var  logic [7:0]  reg_rdata,      // read data
  input  wire logic        p1_copper_link, // link level, async
  input  wire logic        p2_copper_link, // link level, async
  input  wire logic        p3_mii_link,    // link level, async
  input  wire logic        p1_mii_link,    // link level, async
  input  wire logic [2:0]  upper_q_ratio,  // bit 7 of the other splits
  input  wire logic        global_ratio,   // global reg 5 bit 3
  input  wire logic        four_queues,    // 1: four queues, 0: two
  input  wire logic        pause_active,   // forced pause in progress
  output var  logic        irq_out_low,    // interrupt, active low
  output var  logic        pause_end_req,  // one-cycle end request
  output var  sched_type   sched_mode,     // third port scheduling
  output var  logic [15:0] queue_weights,  // q3..q0 nibbles
  output var  logic        ins_p1_to_p2,   // tag insert toward port 2
  output var  logic        ins_p1_to_p3,   // tag insert toward port 3
  output var  logic [1:0]  fiber_thresh,   // port 2, port 1 thresholds
  output var  logic        ldo_off         // regulator disable
);

  localparam logic [`PAUSE_CNT_W-1:0] PAUSE_LIMIT =
    PAUSE_LIMIT_CYCLES[`PAUSE_CNT_W-1:0];

  slice_state_type st_r;
  slice_state_type st_nxt;
  logic [3:0]      chg;
  logic [7:0]      set_vec;
  logic            wr_status;

  // ****************************************
  // link change detection
  // ****************************************
  // first samples after reset are not treated as changes
  assign chg = (st_r.warm == 2'd3) ? (st_r.sync2 ^ st_r.prev) : 4'h0;

  always_comb begin
    set_vec = 8'h00;
    set_vec[`BIT_LC_P1P2] = chg[`LNK_P1_COPPER] | chg[`LNK_P2_COPPER];
    set_vec[`BIT_LC_P3]   = chg[`LNK_P3_MII];
    set_vec[`BIT_LC_P2]   = chg[`LNK_P2_COPPER];
    set_vec[`BIT_LC_P1]   = chg[`LNK_P1_COPPER] | chg[`LNK_P1_MII];
  end

  assign wr_status = reg_wr && (reg_addr == `OFS_LINK_STATUS);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = {p1_mii_link, p3_mii_link, p2_copper_link,
                    p1_copper_link};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = st_r.sync2;
    // three edges fill sync2 and prev before a change may count
    if (st_r.warm != 2'd3) begin
      st_nxt.warm = st_r.warm + 2'd1;
    end

    // register writes; reserved read-only bits ignore data
    if (reg_wr) begin
      if (reg_addr == `OFS_Q0_SPLIT) begin
        st_nxt.ratio_sel = reg_wdata[`BIT_RATIO_SEL];
      end else if (reg_addr == `OFS_IRQ_MASK) begin
        st_nxt.mask = reg_wdata;
      end else if (reg_addr == `OFS_PAUSE_LIMIT) begin
        st_nxt.pause_cfg = reg_wdata;
      end else if (reg_addr == `OFS_FIBER_THRESH) begin
        st_nxt.fiber = {reg_wdata[`BIT_FIBER_P2], reg_wdata[`BIT_FIBER_P1]};
      end else if (reg_addr == `OFS_REGULATOR) begin
        st_nxt.ldo_off = reg_wdata[`BIT_LDO_OFF];
      end else if (reg_addr == `OFS_VLAN_INSERT) begin
        st_nxt.vlan_ins = {reg_wdata[`BIT_INS_P1_TO_P2],
                           reg_wdata[`BIT_INS_P1_TO_P3]};
      end
    end

    // set beats a simultaneous write-one clear
    st_nxt.status = (st_r.status & ~(wr_status ? (reg_wdata & `W1C_MASK)
                                                : 8'h00))
                    | set_vec;
    if (wr_status) begin
      // writable reserved bits are plain storage
      st_nxt.status = (st_nxt.status & ~`RSV_RW_MASK)
                      | (reg_wdata & `RSV_RW_MASK);
    end

    st_nxt.irq_n = ~|(st_nxt.status & st_nxt.mask);

    // forced pause limit; count parks at the limit until pause ends
    st_nxt.pend = 1'b0;
    if (!st_r.pause_cfg[`BIT_PAUSE_EN] || !pause_active) begin
      st_nxt.pcnt = '0;
    end else if (st_r.pcnt != PAUSE_LIMIT) begin
      st_nxt.pcnt = st_r.pcnt + `PAUSE_CNT_W'(1);
      st_nxt.pend = (st_r.pcnt + `PAUSE_CNT_W'(1)) == PAUSE_LIMIT;
    end

    // scheduling select
    if (st_r.ratio_sel) begin
      st_nxt.mode    = SCHED_RATIO;
      st_nxt.weights = four_queues ? `WEIGHTS_FOUR : `WEIGHTS_TWO;
    end else if (!(|upper_q_ratio) && !global_ratio) begin
      st_nxt.mode    = SCHED_STRICT;
      st_nxt.weights = 16'h0000;
    end else begin
      st_nxt.mode    = SCHED_MIXED;
      st_nxt.weights = 16'h0000;
    end

    // read path; unmapped offsets return zero
    if (reg_rd) begin
      if (reg_addr == `OFS_Q0_SPLIT) begin
        st_nxt.rdata = {st_r.ratio_sel, 7'h00};
      end else if (reg_addr == `OFS_IRQ_MASK) begin
        st_nxt.rdata = st_r.mask;
      end else if (reg_addr == `OFS_LINK_STATUS) begin
        st_nxt.rdata = st_r.status;
      end else if (reg_addr == `OFS_PAUSE_LIMIT) begin
        st_nxt.rdata = st_r.pause_cfg;
      end else if (reg_addr == `OFS_FIBER_THRESH) begin
        st_nxt.rdata = {st_r.fiber, 6'h00};
      end else if (reg_addr == `OFS_REGULATOR) begin
        st_nxt.rdata = {1'b0, st_r.ldo_off, 6'h00};
      end else if (reg_addr == `OFS_VLAN_INSERT) begin
        st_nxt.rdata = {2'b00, st_r.vlan_ins, 4'h0};
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r           <= '0;
      st_r.ratio_sel <= `RST_RATIO_SEL;
      st_r.mask      <= `RST_IRQ_MASK;
      st_r.status    <= `RST_LINK_STATUS;
      st_r.pause_cfg <= `RST_PAUSE_LIMIT;
      st_r.irq_n     <= 1'b1;
      st_r.mode      <= SCHED_RATIO;
      st_r.weights   <= `WEIGHTS_TWO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata     = st_r.rdata;
  assign irq_out_low   = st_r.irq_n;
  assign pause_end_req = st_r.pend;
  assign sched_mode    = st_r.mode;
  assign queue_weights = st_r.weights;
  assign ins_p1_to_p2  = st_r.vlan_ins[1];
  assign ins_p1_to_p3  = st_r.vlan_ins[0];
  assign fiber_thresh  = st_r.fiber;
  assign ldo_off       = st_r.ldo_off;

  // ****************************************
  // assertions: scheduling
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RATIO_MODE: assert property (
    st_r.ratio_sel && four_queues |=> sched_mode == SCHED_RATIO
      && queue_weights == 16'h8421)
    else $error("ratio mode not selected");
  AST_TWO_QUEUES: assert property (
    st_r.ratio_sel && !four_queues |=> sched_mode == SCHED_RATIO
      && queue_weights == 16'h0021)
    else $error("two queue ratio not selected");
  AST_STRICT_MODE: assert property (
    !st_r.ratio_sel && upper_q_ratio == 3'b000 && !global_ratio
      |=> sched_mode == SCHED_STRICT)
    else $error("strict mode not selected");
  AST_MIXED_MODE: assert property (
    !st_r.ratio_sel && (upper_q_ratio != 3'b000 || global_ratio)
      |=> sched_mode == SCHED_MIXED)
    else $error("strict mode kept with a ratio bit set");
  AST_NO_WEIGHTS: assert property (
    sched_mode != SCHED_RATIO |-> queue_weights == 16'h0000)
    else $error("weights shown outside ratio mode");
  AST_SELECT_READ: assert property (
    reg_rd && reg_addr == 8'hba
      |=> reg_rdata == {$past(st_r.ratio_sel), 7'h00})
    else $error("queue select read back wrong");

  // ****************************************
  // assertions: interrupt and link change
  // ****************************************
  AST_MASK_WRITE: assert property (
    reg_wr && reg_addr == 8'hbb |=> st_r.mask == $past(reg_wdata))
    else $error("mask write lost");
  AST_IRQ_LEVEL: assert property (
    irq_out_low == !(|(st_r.status & st_r.mask)))
    else $error("interrupt pin does not follow status");
  AST_IRQ_SET: assert property (
    |(set_vec & st_r.mask) && !(reg_wr && reg_addr == 8'hbb)
      |=> !irq_out_low)
    else $error("enabled link change left interrupt idle");
  AST_LC_COPPER1: assert property (
    chg[0] |=> st_r.status[7] && st_r.status[0])
    else $error("first copper change not flagged");
  AST_LC_P3: assert property (
    chg[2] |=> st_r.status[2])
    else $error("third port change not flagged");
  AST_LC_P2: assert property (
    chg[1] |=> st_r.status[1] && st_r.status[7])
    else $error("second port change not flagged");
  AST_LC_P1_MII: assert property (
    chg[3] |=> st_r.status[0])
    else $error("first port interface change not flagged");
  AST_W1C: assert property (
    wr_status && set_vec == 8'h00
      |=> (st_r.status & $past(reg_wdata) & 8'h87) == 8'h00)
    else $error("write one did not clear");
  AST_W1C_KEEP: assert property (
    wr_status |=> ($past(st_r.status) & ~$past(reg_wdata) & 8'h87
      & ~st_r.status) == 8'h00)
    else $error("write zero disturbed a status bit");
  AST_SET_WINS: assert property (
    wr_status && set_vec != 8'h00
      |=> (st_r.status & $past(set_vec)) == $past(set_vec))
    else $error("clear beat a link change");
  AST_STATUS_HOLD: assert property (
    !wr_status && set_vec == 8'h00 |=> $stable(st_r.status))
    else $error("status moved with no event");
  AST_STATUS_READ: assert property (
    reg_rd && reg_addr == 8'hbc |=> reg_rdata == $past(st_r.status))
    else $error("status read back wrong");
  AST_RELEASE: assert property (
    reg_wr && reg_addr == 8'hbb && reg_wdata == 8'h00 |=> irq_out_low)
    else $error("interrupt not released");
  AST_IRQ_QUIET: assert property (
    (st_r.status & st_r.mask) == 8'h00 && set_vec == 8'h00
      && !reg_wr |=> irq_out_low)
    else $error("interrupt held with nothing enabled");

  // ****************************************
  // assertions: pause limit and tag insertion
  // ****************************************
  AST_PAUSE_OFF: assert property (
    !st_r.pause_cfg[0] |=> !pause_end_req)
    else $error("pause end with limit disabled");
  AST_PAUSE_PULSE: assert property (
    pause_end_req |=> !pause_end_req)
    else $error("pause end request longer than a cycle");
  AST_PAUSE_IDLE: assert property (
    !pause_active |=> !pause_end_req)
    else $error("pause end without forced pause");
  AST_VLAN_INSERT: assert property (
    reg_wr && reg_addr == 8'hc2 |=> ins_p1_to_p2 == $past(reg_wdata[5])
      && ins_p1_to_p3 == $past(reg_wdata[4]))
    else $error("tag insert enable not taken");

  // ****************************************
  // covers
  // ****************************************
  COV_IRQ: cover property (irq_out_low ##1 !irq_out_low);
  COV_PAUSE_END: cover property (pause_end_req);
  COV_CLEAR_IRQ: cover property (!irq_out_low ##[1:20] irq_out_low);
  COV_MIXED: cover property (sched_mode == SCHED_MIXED);
  COV_W1C: cover property (wr_status && (reg_wdata & st_r.status) != 8'h00);

endmodule

`default_nettype wire

// File: hdl/switch_adv_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit register port, 25 MHz clock
// Notes:   definitions only
`ifndef SWITCH_ADV_CONSTS_SVH
`define SWITCH_ADV_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_Q0_SPLIT      8'hba
`define OFS_IRQ_MASK      8'hbb
`define OFS_LINK_STATUS   8'hbc
`define OFS_PAUSE_LIMIT   8'hbd
`define OFS_FIBER_THRESH  8'hc0
`define OFS_REGULATOR     8'hc1
`define OFS_VLAN_INSERT   8'hc2

// ****************************************
// field positions and reset values
// ****************************************
`define BIT_RATIO_SEL     7
`define RST_RATIO_SEL     1'b1
`define BIT_LC_P1P2       7
`define BIT_LC_P3         2
`define BIT_LC_P2         1
`define BIT_LC_P1         0
`define W1C_MASK          8'h87
`define RSV_RW_MASK       8'h78
`define RST_IRQ_MASK      8'h00
`define RST_LINK_STATUS   8'h00
`define RST_PAUSE_LIMIT   8'h00
`define BIT_PAUSE_EN      0
`define BIT_FIBER_P2      7
`define BIT_FIBER_P1      6
`define BIT_LDO_OFF       6
`define BIT_INS_P1_TO_P2  5
`define BIT_INS_P1_TO_P3  4
`define LNK_P1_COPPER     0
`define LNK_P2_COPPER     1
`define LNK_P3_MII        2
`define LNK_P1_MII        3
`define WEIGHTS_FOUR      16'h8421
`define WEIGHTS_TWO       16'h0021

// ****************************************
// timing
// ****************************************
`define CLK_HZ            25000000
`define PAUSE_LIMIT_MS    160
`define PAUSE_CNT_W       22

`endif

// File: hdl/switch_adv_pkg.sv
// Purpose: types shared by the advanced control slice
// Assumes: constants header on the include path
// Notes:   state record registered as one unit
`include "switch_adv_consts.svh"

package switch_adv_pkg;

  typedef enum logic [1:0] {
    SCHED_STRICT,
    SCHED_RATIO,
    SCHED_MIXED
  } sched_type;

  typedef struct packed {
    logic [3:0]              sync1;
    logic [3:0]              sync2;
    logic [3:0]              prev;
    logic [1:0]              warm;
    logic                    ratio_sel;
    logic [7:0]              mask;
    logic [7:0]              status;
    logic [7:0]              pause_cfg;
    logic [1:0]              fiber;
    logic                    ldo_off;
    logic [1:0]              vlan_ins;
    logic [`PAUSE_CNT_W-1:0] pcnt;
    logic                    pend;
    logic [7:0]              rdata;
    logic                    irq_n;
    sched_type               mode;
    logic [15:0]             weights;
  } slice_state_type;

endpackage

// File: testbench/switch_adv_control_slice_tb.sv
// Purpose: self-checking bench for the advanced control slice
// Assumes: design built with a short pause limit
// Notes:   inputs move on rising edges by non-blocking assignment
`timescale 1ns/1ps
`default_nettype none

module switch_adv_control_slice_tb
  import switch_adv_pkg::*;
();
  localparam int unsigned LIMIT = 20;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [3:0]  lnk = 4'h0;
  logic [2:0]  upq = 3'h0;
  logic        glob = 1'b0;
  logic        fourq = 1'b0;
  logic        pact = 1'b0;
  logic        irq_out_low;
  logic        pend;
  sched_type   sched_mode;
  logic [15:0] queue_weights;
  logic        ins2;
  logic        ins3;
  logic [1:0]  fiber;
  logic        ldo;
  int          fails = 0;
  int          num_checks = 0;

  always #20 clk = ~clk;

  switch_adv_control_slice #(
    .PAUSE_LIMIT_CYCLES(LIMIT)
  ) switch_adv_control_slice_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .p1_copper_link(lnk[0]), .p2_copper_link(lnk[1]),
    .p3_mii_link(lnk[2]), .p1_mii_link(lnk[3]), .upper_q_ratio(upq),
    .global_ratio(glob), .four_queues(fourq), .pause_active(pact),
    .irq_out_low(irq_out_low), .pause_end_req(pend),
    .sched_mode(sched_mode), .queue_weights(queue_weights),
    .ins_p1_to_p2(ins2), .ins_p1_to_p3(ins3), .fiber_thresh(fiber),
    .ldo_off(ldo));

  // ****************************************
  // compares and bus cycles
  // ****************************************
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check_val({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic reset_values();
    rd_chk(8'hba, 8'h80);
    rd_chk(8'hbb, 8'h00);
    rd_chk(8'hbc, 8'h00);
    rd_chk(8'hbd, 8'h00);
    rd_chk(8'hc2, 8'h00);
    rd_chk(8'hbe, 8'h00);
    check_bit(irq_out_low, 1'b1);
  endtask

  task automatic sched_select();
    check_val(queue_weights, 16'h0021);
    check_val({14'h0, sched_mode}, {14'h0, SCHED_RATIO});
    @(posedge clk);
    fourq <= 1'b1;
    settle(2);
    check_val(queue_weights, 16'h8421);
    wr(8'hba, 8'h00);
    settle(2);
    check_val({14'h0, sched_mode}, {14'h0, SCHED_STRICT});
    check_val(queue_weights, 16'h0000);
    @(posedge clk);
    glob <= 1'b1;
    settle(2);
    check_val({14'h0, sched_mode}, {14'h0, SCHED_MIXED});
    @(posedge clk);
    glob <= 1'b0;
    upq <= 3'h4;
    settle(2);
    check_val({14'h0, sched_mode}, {14'h0, SCHED_MIXED});
    @(posedge clk);
    upq <= 3'h0;
    wr(8'hba, 8'h80);
  endtask

  task automatic link_event(input int pin, input logic [7:0] exp);
    @(posedge clk);
    lnk[pin] <= ~lnk[pin];
    settle(5);
    rd_chk(8'hbc, exp);
    wr(8'hbc, 8'h87);
    rd_chk(8'hbc, 8'h00);
  endtask

  task automatic irq_path();
    wr(8'hbb, 8'h03);
    wr(8'hbc, 8'h87);
    settle(2);
    check_bit(irq_out_low, 1'b1);
    @(posedge clk);
    lnk[1] <= ~lnk[1];
    settle(5);
    check_bit(irq_out_low, 1'b0);
    rd_chk(8'hbc, 8'h82);
    wr(8'hbc, 8'h00);
    rd_chk(8'hbc, 8'h82);
    wr(8'hbc, 8'h02);
    settle(2);
    check_bit(irq_out_low, 1'b1);
    @(posedge clk);
    lnk[1] <= ~lnk[1];
    settle(5);
    check_bit(irq_out_low, 1'b0);
    wr(8'hbb, 8'h80);
    settle(2);
    check_bit(irq_out_low, 1'b0);
    wr(8'hbb, 8'h00);
    settle(2);
    check_bit(irq_out_low, 1'b1);
    wr(8'hbc, 8'h87);
  endtask

  // pause seen high from the edge after the enable write
  task automatic pause_limit(input logic en);
    wr(8'hbd, {7'h0, en});
    pact <= 1'b1;
    settle(LIMIT - 1);
    check_bit(pend, 1'b0);
    settle(1);
    check_bit(pend, en);
    settle(1);
    check_bit(pend, 1'b0);
    @(posedge clk);
    pact <= 1'b0;
    rd_chk(8'hbd, {7'h0, en});
  endtask

  task automatic insert_and_misc();
    wr(8'hc2, 8'h20);
    settle(2);
    check_val({14'h0, ins2, ins3}, 16'h0002);
    wr(8'hc2, 8'h10);
    rd_chk(8'hc2, 8'h10);
    check_val({14'h0, ins2, ins3}, 16'h0001);
    wr(8'hc0, 8'hc0);
    wr(8'hc1, 8'h40);
    settle(2);
    check_val({13'h0, fiber, ldo}, 16'h0007);
    rd_chk(8'hc0, 8'hc0);
    rd_chk(8'hc1, 8'h40);
  endtask

  // links stay up across reset; no change may be flagged after it
  task automatic reset_midrun();
    @(posedge clk);
    rst <= 1'b1;
    settle(2);
    @(posedge clk);
    rst <= 1'b0;
    settle(4);
    rd_chk(8'hba, 8'h80);
    rd_chk(8'hbb, 8'h00);
    rd_chk(8'hbc, 8'h00);
    rd_chk(8'hc2, 8'h00);
    check_bit(irq_out_low, 1'b1);
    check_val(queue_weights, 16'h8421);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle(4);
    reset_values();
    sched_select();
    link_event(0, 8'h81);
    link_event(1, 8'h82);
    link_event(2, 8'h04);
    link_event(3, 8'h01);
    irq_path();
    pause_limit(1'b1);
    pause_limit(1'b0);
    insert_and_misc();
    reset_midrun();
    tally_and_finish();
  end

  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
